// File: src/goose_input_function_mapper.sv
// input function mapper for accepted subscribed messages, apb registers
// assumes a pre-parsed message with msg_valid pulsed once per frame
`timescale 1ns/1ps
`include "goose_map_defines.svh"

module goose_input_function_mapper #(
  parameter int MS_CYCLES = `GM_MS_CYCLES
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         nrst,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [`GM_ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic [31:0]                       prdata,
  // parsed message
  input  wire logic                         msg_valid,
  input  wire goose_map_pkg::msg_header_type msg_header,
  input  wire goose_map_pkg::msg_body_type  msg_body,
  // test progress from the test engines
  input  wire logic                         checkback_busy,
  input  wire logic                         loop_busy,
  input  wire logic                         trip_test_busy,
  // commands and status
  output goose_map_pkg::tx_cmd_type         tx_cmd,
  output goose_map_pkg::test_start_type     test_start,
  output logic                              msg_accepted,
  output logic                              msg_rejected
);

  // ==========================================
  // configuration and state
  logic [31:0]                        ctrl;
  logic [47:0]                        cfg_dest;
  logic [2:0]                         cfg_vlan;
  logic [15:0]                        cfg_app;
  logic [15:0]                        cfg_gocb;
  logic [15:0]                        cfg_datset;
  logic [15:0]                        cfg_ttl;
  goose_map_pkg::func_code_type       map_code [`GM_ENTRY_MAX];
  logic [`GM_ENTRY_MAX-1:0]           entry_value;
  logic [15:0]                        accept_count;
  logic [15:0]                        reject_count;
  logic [$clog2(MS_CYCLES)-1:0]       ms_div;
  logic [15:0]                        age_ms;
  logic                               stale;

  // ==========================================
  // helpers
  // mask of entries below a count
  function automatic logic [`GM_ENTRY_MAX-1:0] count_mask(input logic [4:0] count);
    logic [`GM_ENTRY_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < `GM_ENTRY_MAX; i++) begin
      m[i] = (5'(i) < count);
    end
    return m;
  endfunction

  // level of one function over all held entries
  // table passed in so a remap re-evaluates every level at once
  function automatic logic fn_level(input goose_map_pkg::func_code_type code,
                                    input goose_map_pkg::func_code_type codes [`GM_ENTRY_MAX],
                                    input logic [`GM_ENTRY_MAX-1:0] vals);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `GM_ENTRY_MAX; i++) begin
      // entry i drives map slot i
      hit = hit | (vals[i] & (codes[i] == code));
    end
    return hit;
  endfunction

  // ==========================================
  // control field decode
  wire logic                       mode_fsk = ctrl[`GM_CTRL_FSK];
  wire logic                       mode_onoff = ~ctrl[`GM_CTRL_FSK];
  wire goose_map_pkg::scheme_type  scheme =
    goose_map_pkg::scheme_type'(ctrl[`GM_CTRL_SCH_HI:`GM_CTRL_SCH_LO]);
  wire logic                       stop_first = ctrl[`GM_CTRL_STOP_PRI];
  wire logic                       cb_enable = ctrl[`GM_CTRL_CB_EN];
  wire logic                       loop_enable = ctrl[`GM_CTRL_LOOP_EN];
  wire logic                       tt_enable = ctrl[`GM_CTRL_TT_EN];
  wire logic [4:0]                 cfg_count = ctrl[`GM_CTRL_CNT_HI:`GM_CTRL_CNT_LO];
  wire logic [`GM_ENTRY_MAX-1:0]   cfg_mask = count_mask(cfg_count);
  wire logic                       three_up = (scheme == goose_map_pkg::scheme_three) |
                                              (scheme == goose_map_pkg::scheme_four);
  wire logic                       four_only = (scheme == goose_map_pkg::scheme_four);

  // ==========================================
  // message acceptance
  // identity match at each layer
  wire logic hdr_ok = (msg_header.dest_addr == cfg_dest) &
                      (msg_header.vlan_prio == cfg_vlan) &
                      (msg_header.app_id == cfg_app) &
                      (msg_header.gocb_ref_id == cfg_gocb) &
                      (msg_header.datset_ref_id == cfg_datset);
  // entry count must equal map count
  wire logic count_ok = (msg_body.count == cfg_count);
  wire logic bool_ok = &(msg_body.is_bool | ~cfg_mask);
  wire logic accept = msg_valid & hdr_ok & count_ok & bool_ok;
  wire logic reject = msg_valid & ~accept;

  // ==========================================
  // time to live supervision
  // age in ms against configured maximum
  wire logic ms_tick = (ms_div == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  wire logic expire = (cfg_ttl != 16'h0000) & (age_ms >= cfg_ttl);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ms_div <= '0;
      age_ms <= 16'h0000;
      stale  <= 1'b1;
    end else begin
      ms_div <= (accept | ms_tick) ? '0 : ms_div + 1'b1;
      age_ms <= accept ? 16'h0000 : (ms_tick & ~expire) ? age_ms + 16'h0001 : age_ms;
      stale  <= accept ? 1'b0 : (expire | stale);
    end
  end

  // held entry values, cleared once stale
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      entry_value <= '0;
    end else if (accept) begin
      entry_value <= msg_body.value & cfg_mask;
    end else if (expire) begin
      entry_value <= '0;
    end
  end

  // accept / reject pulses and counts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      msg_accepted <= 1'b0;
      msg_rejected <= 1'b0;
      accept_count <= 16'h0000;
      reject_count <= 16'h0000;
    end else begin
      msg_accepted <= accept;
      msg_rejected <= reject;
      accept_count <= accept_count + 16'(accept);
      reject_count <= reject_count + 16'(reject);
    end
  end

  // ==========================================
  // function levels; ignore_entry is never decoded
  // do-nothing code has no consumer
  wire logic [`GM_ENTRY_MAX-1:0] held = entry_value & cfg_mask;
  wire logic on_lvl   = fn_level(goose_map_pkg::onoff_tx_on, map_code, held);
  wire logic off_lvl  = fn_level(goose_map_pkg::onoff_tx_off, map_code, held);
  wire logic low_lvl  = fn_level(goose_map_pkg::onoff_low_power_key, map_code, held);
  wire logic cbc_lvl  = fn_level(goose_map_pkg::checkback_alarm_clear, map_code, held);
  wire logic cbs_lvl  = fn_level(goose_map_pkg::checkback_test_start, map_code, held);
  wire logic lps_lvl  = fn_level(goose_map_pkg::loop_test_start, map_code, held);
  wire logic brk_lvl  = fn_level(goose_map_pkg::fsk_breaker_boost_key, map_code, held);
  wire logic trp_lvl  = fn_level(goose_map_pkg::fsk_trip_key_a, map_code, held);
  wire logic lr_lvl   = fn_level(goose_map_pkg::fsk_last_remote_key, map_code, held);
  wire logic dtt_lvl  = fn_level(goose_map_pkg::fsk_direct_transfer_key, map_code, held);
  wire logic a_lvl    = fn_level(goose_map_pkg::fsk_channel_a_key, map_code, held);
  wire logic b_lvl    = fn_level(goose_map_pkg::fsk_channel_b_key, map_code, held);
  wire logic foff_lvl = fn_level(goose_map_pkg::fsk_tx_off, map_code, held);
  wire logic tts_lvl  = fn_level(goose_map_pkg::trip_test_start, map_code, held);
  wire logic tti_lvl  = fn_level(goose_map_pkg::trip_test_inhibit, map_code, held);
  wire logic ttc_lvl  = fn_level(goose_map_pkg::trip_test_alarm_clear, map_code, held);

  // ==========================================
  // command decode
  goose_map_pkg::tx_cmd_type next_tx_cmd;
  assign next_tx_cmd.tx_on = mode_onoff & on_lvl & ~(off_lvl & stop_first);
  assign next_tx_cmd.tx_off = mode_onoff & off_lvl & (~on_lvl | stop_first);
  assign next_tx_cmd.low_power = mode_onoff & low_lvl;
  assign next_tx_cmd.checkback_alarm_clear = mode_onoff & cbc_lvl;
  assign next_tx_cmd.breaker_boost = mode_fsk & brk_lvl;
  assign next_tx_cmd.trip_key = mode_fsk & trp_lvl;
  // last remote needs three or four
  assign next_tx_cmd.last_remote_key = mode_fsk & three_up & lr_lvl;
  // direct transfer needs three or four
  assign next_tx_cmd.direct_transfer_key = mode_fsk & three_up & dtt_lvl;
  assign next_tx_cmd.channel_a_key = mode_fsk & four_only & a_lvl;
  assign next_tx_cmd.channel_b_key = mode_fsk & four_only & b_lvl;
  assign next_tx_cmd.fsk_tx_off = mode_fsk & foff_lvl;
  assign next_tx_cmd.trip_test_inhibit = mode_fsk & tti_lvl;
  assign next_tx_cmd.trip_test_alarm_clear = mode_fsk & ttc_lvl;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_cmd <= '0;
    end else begin
      tx_cmd <= next_tx_cmd;
    end
  end

  // ==========================================
  // test start launchers
  // local enable overrides mapped start
  // checkback start, busy shown in status
  test_start_gate u_checkback (
    .clock  (clock),
    .nrst   (nrst),
    .level  (cbs_lvl),
    .enable (mode_onoff & cb_enable),
    .busy   (checkback_busy),
    .start  (test_start.checkback)
  );

  test_start_gate u_loop (
    .clock  (clock),
    .nrst   (nrst),
    .level  (lps_lvl),
    .enable (mode_onoff & loop_enable),
    .busy   (loop_busy),
    .start  (test_start.loop)
  );

  // trip test also blocked by its own inhibit
  test_start_gate u_trip_test (
    .clock  (clock),
    .nrst   (nrst),
    .level  (tts_lvl),
    .enable (mode_fsk & tt_enable & ~tti_lvl),
    .busy   (trip_test_busy),
    .start  (test_start.trip_test)
  );

  // ==========================================
  // apb slave: one wait state, registered answer
  wire logic apb_access = psel & penable & ~pready;
  wire logic apb_write = psel & penable & pready & pwrite;
  wire logic map_hit = (paddr >= `GM_REG_MAP0) & (paddr <= `GM_REG_MAP3) &
                       (paddr[1:0] == 2'b00);
  wire logic [1:0] map_reg = 2'((paddr - `GM_REG_MAP0) >> 2);
  wire logic [31:0] map_word = {3'b000, map_code[{map_reg, 2'b11}],
                                3'b000, map_code[{map_reg, 2'b10}],
                                3'b000, map_code[{map_reg, 2'b01}],
                                3'b000, map_code[{map_reg, 2'b00}]};
  wire logic [31:0] status_word = {12'h000, trip_test_busy, loop_busy, checkback_busy,
                                   stale, entry_value};
  logic [31:0] next_prdata;
  logic        next_err;

  // read decode
  always_comb begin
    next_err = 1'b0;
    unique case (paddr)
      `GM_REG_CTRL:    next_prdata = ctrl;
      `GM_REG_DEST_LO: next_prdata = cfg_dest[31:0];
      `GM_REG_DEST_HI: next_prdata = {13'h0000, cfg_vlan, cfg_dest[47:32]};
      `GM_REG_APP:     next_prdata = {16'h0000, cfg_app};
      `GM_REG_REF:     next_prdata = {cfg_datset, cfg_gocb};
      `GM_REG_TTL:     next_prdata = {16'h0000, cfg_ttl};
      `GM_REG_STATUS:  next_prdata = status_word;
      `GM_REG_CMD:     next_prdata = 32'(tx_cmd);
      `GM_REG_COUNT:   next_prdata = {reject_count, accept_count};
      default: begin
        next_prdata = map_hit ? map_word : `GM_ZERO32;
        next_err    = ~map_hit;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `GM_ZERO32;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & next_err;
      prdata  <= (apb_access & ~pwrite) ? next_prdata : `GM_ZERO32;
    end
  end

  // register writes at the completing edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl       <= `GM_CTRL_RESET;
      cfg_dest   <= '0;
      cfg_vlan   <= '0;
      cfg_app    <= '0;
      cfg_gocb   <= '0;
      cfg_datset <= '0;
      cfg_ttl    <= `GM_TTL_RESET;
    end else if (apb_write) begin
      if (paddr == `GM_REG_CTRL) ctrl <= pwdata;
      if (paddr == `GM_REG_DEST_LO) cfg_dest[31:0] <= pwdata;
      if (paddr == `GM_REG_DEST_HI) begin
        cfg_dest[47:32] <= pwdata[15:0];
        cfg_vlan        <= pwdata[`GM_VLAN_HI:`GM_VLAN_LO];
      end
      if (paddr == `GM_REG_APP) cfg_app <= pwdata[15:0];
      if (paddr == `GM_REG_REF) {cfg_datset, cfg_gocb} <= pwdata;
      if (paddr == `GM_REG_TTL) cfg_ttl <= pwdata[15:0];
    end
  end

  // mapping table, four codes per word
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `GM_ENTRY_MAX; i++) map_code[i] <= goose_map_pkg::ignore_entry;
    end else if (apb_write & map_hit) begin
      for (int k = 0; k < `GM_MAPS_PER_REG; k++) begin
        map_code[{map_reg, 2'(k)}] <=
          goose_map_pkg::func_code_type'(pwdata[k*`GM_MAP_FIELD_W +: `GM_CODE_W]);
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb_main @(posedge clock); endclocking
  default disable iff (!nrst);

  a_count_reject: assert property (
    msg_valid && (msg_body.count != cfg_count) |=> msg_rejected && !msg_accepted)
    else $error("count mismatch not rejected");

  a_bool_reject: assert property (
    msg_valid && !(&(msg_body.is_bool | ~cfg_mask)) |=> msg_rejected)
    else $error("non boolean entry accepted");

  a_ident_reject: assert property (
    msg_valid && (msg_header.app_id != cfg_app) |=> !msg_accepted)
    else $error("foreign application id accepted");

  a_entry_position: assert property (
    msg_accepted |-> entry_value == ($past(msg_body.value) & $past(cfg_mask)))
    else $error("entries not held by position");

  a_onoff_mode: assert property (
    tx_cmd.tx_on || tx_cmd.low_power |-> !$past(mode_fsk))
    else $error("on-off function acted in fsk mode");

  a_stop_priority: assert property (
    mode_onoff && on_lvl && off_lvl && stop_first |=> tx_cmd.tx_off && !tx_cmd.tx_on)
    else $error("stop priority not honoured");

  a_four_freq: assert property (
    tx_cmd.channel_a_key || tx_cmd.channel_b_key |-> $past(four_only) && $past(mode_fsk))
    else $error("channel key outside four frequency mode");

  a_three_up: assert property (
    tx_cmd.last_remote_key |-> $past(three_up))
    else $error("last remote key in two frequency mode");

  a_local_override: assert property (
    test_start.checkback |-> $past(cb_enable) && $past(mode_onoff))
    else $error("checkback started while disabled");

  a_stale_clear: assert property (
    expire && !accept |=> entry_value == '0 && stale)
    else $error("expired entries not cleared");

  c_accept: cover property (msg_accepted);
  c_stale: cover property (expire ##1 stale);
  c_checkback: cover property (test_start.checkback);
  c_trip_test: cover property (test_start.trip_test);

endmodule

// File: src/goose_map_defines.svh
// constants for the subscribed-message input function mapper
// assumes a 20 MHz clock and 32-bit apb data with byte addresses
`ifndef GOOSE_MAP_DEFINES_SVH
`define GOOSE_MAP_DEFINES_SVH

// ==========================================
// sizes
`define GM_ENTRY_MAX     16
`define GM_COUNT_W       5
`define GM_CODE_W        5
`define GM_MAPS_PER_REG  4
`define GM_MAP_FIELD_W   8
`define GM_ADDR_W        8

// ==========================================
// register byte offsets
`define GM_REG_CTRL      8'h00
`define GM_REG_DEST_LO   8'h04
`define GM_REG_DEST_HI   8'h08
`define GM_REG_APP       8'h0c
`define GM_REG_REF       8'h10
`define GM_REG_TTL       8'h14
`define GM_REG_MAP0      8'h18
`define GM_REG_MAP3      8'h24
`define GM_REG_STATUS    8'h28
`define GM_REG_CMD       8'h2c
`define GM_REG_COUNT     8'h30

// ==========================================
// control fields
`define GM_CTRL_FSK      0
`define GM_CTRL_SCH_LO   1
`define GM_CTRL_SCH_HI   2
`define GM_CTRL_STOP_PRI 3
`define GM_CTRL_CB_EN    4
`define GM_CTRL_LOOP_EN  5
`define GM_CTRL_TT_EN    6
`define GM_CTRL_CNT_LO   8
`define GM_CTRL_CNT_HI   12
`define GM_CTRL_RESET    32'h0000_0070

// ==========================================
// other fields and reset values
`define GM_VLAN_LO       16
`define GM_VLAN_HI       18
`define GM_STAT_STALE    16
`define GM_STAT_CB_BUSY  17
`define GM_STAT_LP_BUSY  18
`define GM_STAT_TT_BUSY  19
`define GM_ZERO32        32'h0000_0000
`define GM_TTL_RESET     16'h01f4

// ==========================================
// timing
`define GM_MS_NS         1000000
`define GM_CLOCK_NS      50
`define GM_MS_CYCLES     (`GM_MS_NS / `GM_CLOCK_NS)

`endif

// File: src/goose_map_pkg.sv
// types for the subscribed-message input function mapper
// assumes goose_map_defines.svh is compiled alongside
package goose_map_pkg;

  // ==========================================
  // input function codes held per mapping entry
  typedef enum logic [4:0] {
    ignore_entry          = 5'h00,
    onoff_tx_on           = 5'h01,
    onoff_tx_off          = 5'h02,
    onoff_low_power_key   = 5'h03,
    checkback_alarm_clear = 5'h04,
    checkback_test_start  = 5'h05,
    loop_test_start       = 5'h06,
    fsk_breaker_boost_key = 5'h07,
    fsk_trip_key_a        = 5'h08,
    fsk_last_remote_key   = 5'h09,
    fsk_direct_transfer_key = 5'h0a,
    fsk_channel_a_key     = 5'h0b,
    fsk_channel_b_key     = 5'h0c,
    fsk_tx_off            = 5'h0d,
    trip_test_start       = 5'h0e,
    trip_test_inhibit     = 5'h0f,
    trip_test_alarm_clear = 5'h10
  } func_code_type;

  // ==========================================
  // frequency scheme of the fsk application
  typedef enum logic [1:0] {
    scheme_two   = 2'b00,
    scheme_three = 2'b01,
    scheme_four  = 2'b10
  } scheme_type;

  // ==========================================
  // identity fields of a received message
  typedef struct packed {
    logic [47:0] dest_addr;
    logic [2:0]  vlan_prio;
    logic [15:0] app_id;
    logic [15:0] gocb_ref_id;
    logic [15:0] datset_ref_id;
  } msg_header_type;

  // data entries of a received message
  typedef struct packed {
    logic [4:0]  count;
    logic [15:0] is_bool;
    logic [15:0] value;
  } msg_body_type;

  // ==========================================
  // transmitter and alarm commands, levels
  typedef struct packed {
    logic tx_on;
    logic tx_off;
    logic low_power;
    logic checkback_alarm_clear;
    logic breaker_boost;
    logic trip_key;
    logic last_remote_key;
    logic direct_transfer_key;
    logic channel_a_key;
    logic channel_b_key;
    logic fsk_tx_off;
    logic trip_test_inhibit;
    logic trip_test_alarm_clear;
  } tx_cmd_type;

  // test start pulses
  typedef struct packed {
    logic checkback;
    logic loop;
    logic trip_test;
  } test_start_type;

endpackage

// File: src/test_start_gate.sv
// rising-edge launcher for one test start function
// assumes level comes from a flop in the same clock domain
`timescale 1ns/1ps

module test_start_gate (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // request and qualifiers
  input  wire logic level,
  input  wire logic enable,
  input  wire logic busy,
  // one-cycle start pulse
  output logic      start
);

  logic prev;

  // ==========================================
  // edge detect
  // rising edge only
  wire logic rise = level & ~prev;

  // edge during a test is dropped, prev still follows
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev  <= 1'b0;
      start <= 1'b0;
    end else begin
      prev  <= level;
      start <= rise & enable & ~busy;
    end
  end

  // ==========================================
  // checks
  a_start_on_edge: assert property (@(posedge clock) disable iff (!nrst)
    start |-> $past(level) && !$past(level, 2))
    else $error("start without a rising edge");

  a_busy_drops_edge: assert property (@(posedge clock) disable iff (!nrst)
    busy |=> !start)
    else $error("start issued while test busy");

endmodule

// File: tb/goose_publisher.sv
// publisher model: sends parsed frames to the mapper
// assumes the bench calls send from its clocked sequence
`timescale 1ns/1ps

module goose_publisher (
  // clock
  input  wire logic                     clock,
  // frame toward the mapper
  output logic                          msg_valid,
  output goose_map_pkg::msg_header_type msg_header,
  output goose_map_pkg::msg_body_type   msg_body
);
  // idle, identity left at zero
  initial begin
    msg_valid = 1'b0;
    msg_header = '0;
    msg_body = '0;
  end

  task send(input logic [4:0] n, input logic [15:0] b, input logic [15:0] v);
    @(posedge clock);
    msg_valid <= 1'b1;
    msg_body <= {n, b, v};
    @(posedge clock);
    msg_valid <= 1'b0;
    msg_body <= ~{n, b, v}; // stale body is not held
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the input function mapper
// assumes the publisher model drives the frame inputs
`timescale 1ns/1ps
`define CHK(n,e,s) begin check_count++; if ((s)!==(e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end

module tb_top;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, cb_busy, err;
  logic msg_valid, msg_accepted, msg_rejected;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rnd;
  logic [1:0] note;
  logic [1:0] exq[$];
  goose_map_pkg::msg_header_type hdr;
  goose_map_pkg::msg_body_type body;
  goose_map_pkg::tx_cmd_type tx_cmd;
  goose_map_pkg::test_start_type test_start;
  int err_count = 0;
  int check_count = 0;
  int n_cb = 0;

  // ==========================================
  // design and far side
  goose_input_function_mapper #(.MS_CYCLES(20)) DUT (.clock(clock), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .msg_valid(msg_valid),
    .msg_header(hdr), .msg_body(body), .checkback_busy(cb_busy), .loop_busy(1'b0),
    .trip_test_busy(1'b0), .tx_cmd(tx_cmd), .test_start(test_start),
    .msg_accepted(msg_accepted), .msg_rejected(msg_rejected));
  goose_publisher PUB (.clock(clock), .msg_valid(msg_valid), .msg_header(hdr),
    .msg_body(body));

  // 50 ns clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // apb transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge clock);
    if (i == 20) begin
      err_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // note the verdict, then send
  task msg(input logic [4:0] n, input logic [15:0] b, v, input logic [1:0] e);
    exq.push_back(e);
    PUB.send(n, b, v);
  endtask

  // verdict watcher and start counter
  always @(posedge clock) begin
    if (msg_accepted === 1'b1 || msg_rejected === 1'b1) begin
      note = exq.size() ? exq.pop_front() : 2'b00;
      `CHK("verdict", note, {msg_accepted, msg_rejected})
    end
    if (test_start.checkback === 1'b1)
      n_cb++;
  end

  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, cb_busy} = '0;
    rnd = lfsr(16'h3290) | 16'h1000;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0000_0070, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 8'h14, {16'h0, rnd});
    apb(1'b0, 8'h14, 32'h0);
    `CHK("ttl", rnd, rd[15:0])
    apb(1'b1, 8'h00, 32'h0000_0270);
    apb(1'b1, 8'h18, 32'h0000_0501);
    msg(5'h2, 16'h3, 16'h1, 2'b10);
    msg(5'h3, 16'h7, 16'h0, 2'b01);
    msg(5'h2, 16'h1, 16'h0, 2'b01);
    apb(1'b1, 8'h0c, 32'h0000_0001);
    msg(5'h2, 16'h3, 16'h0, 2'b01);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    `CHK("tx_on", 32'h0000_1000, rd)
    msg(5'h2, 16'h3, 16'h3, 2'b10);
    msg(5'h2, 16'h3, 16'h3, 2'b10);
    cb_busy <= 1'b1;
    msg(5'h2, 16'h3, 16'h1, 2'b10);
    msg(5'h2, 16'h3, 16'h3, 2'b10);
    repeat (3) @(posedge clock);
    `CHK("starts", 1, n_cb)
    apb(1'b1, 8'h00, 32'h0000_0271);
    apb(1'b0, 8'h2c, 32'h0);
    `CHK("fsk gate", 32'h0, rd)
    `CHK("verdicts left", 0, exq.size())
    stop_test();
  end
endmodule
